// >>> sics_pkg.sv
package sics_pkg;

  // ---------------------------------------------------------------
  // Encodings and key values
  // ---------------------------------------------------------------
  localparam logic [1:0] SICS_PSM_IDLE_A = 2'h0;
  localparam logic [1:0] SICS_PSM_IDLE_B = 2'h2;
  localparam logic [7:0] SICS_PROT_KEY = 8'hc9;
  localparam logic [7:0] SICS_PROT_LOCK = 8'h00;
  localparam logic [7:0] SICS_LVL_LOW = 8'h02;
  localparam logic [7:0] SICS_LVL_RST = 8'h00;
  localparam logic [1:0] SICS_SYNC_RST = 2'h0;
  localparam int SICS_NCSI = 5;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SICS_RUN,
    SICS_ARMED,
    SICS_IDLE
  } sics_state_type;

  // Software writes to the power-save and regulator registers
  typedef struct packed {
    logic [1:0] save_mode_select;
    logic standby_trigger_bit;
    logic store_done;
    logic prot_wr;
    logic lvl_wr;
    logic [7:0] wdata;
  } sics_sw_type;

  // Count clock selections of the peripherals that may keep running
  typedef struct packed {
    logic [SICS_NCSI-1:0] serial_ext_clock_sel;
    logic async_ext_clock_sel;
    logic tmm_slow_sel;
    logic wdt_slow_sel;
    logic wt_sub_sel;
    logic main_osc_on;
  } sics_clksel_type;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic periph;
    logic [SICS_NCSI-1:0] csi;
    logic uart0;
    logic tmm;
    logic wdt;
    logic wt;
  } sics_clken_type;

  typedef struct packed {
    logic adc;
    logic dac;
    logic realtime_output_unit;
    logic ports;
    logic ram;
    logic intc_wake_only;
  } sics_hold_type;

endpackage

// >>> sics_reg_guard.sv
module sics_reg_guard
  import sics_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic prot_wr,
  input wire logic lvl_wr,
  input wire logic [7:0] wdata,
  output logic unlocked_q,
  output logic [7:0] level_q
);

  // ---------------------------------------------------------------
  // Write-protect and regulator level registers
  // ---------------------------------------------------------------
  logic [7:0] prot_q;
  logic [7:0] prot_d;
  logic [7:0] level_d;
  wire lvl_take = lvl_wr & (prot_q == SICS_PROT_KEY); // see RQ10

  assign prot_d = prot_wr ? wdata : prot_q;
  assign level_d = lvl_take ? wdata : level_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prot_q <= SICS_PROT_LOCK;
      level_q <= SICS_LVL_RST;
      unlocked_q <= 1'b0;
    end else if (ce) begin
      prot_q <= prot_d;
      level_q <= level_d;
      unlocked_q <= (prot_d == SICS_PROT_KEY);
    end
  end

endmodule // sics_reg_guard

// >>> sics_standby_ctrl.sv
// Summary of operation
// RQ1 - In subclock mode, mode 00 or 10 plus trigger write enters sub-idle.
// RQ2 - Entry with regulator level 02H gives low-voltage sub-idle instead.
// RQ3 - Sub-idle gates CPU, flash and peripheral clocks; oscillator runs.
// RQ4 - Sub-idle halts execution and holds internal RAM unchanged.
// RQ5 - Peripherals clocked by subclock or external clock keep running; the controller gates the externally clocked ones in low-voltage sub-idle.
// RQ6 - Far side stops external serial clocks before low-voltage sub-idle.
// RQ7 - Software first stops main clock and PLL in subclock mode.
// RQ8 - Software disables DMA, interrupts and both edge enables before unlock.
// RQ9 - Software makes sure watchdog interrupt cannot occur before unlock.
// RQ10 - Level register writable only after C9H key; 00H relocks.
// RQ11 - Level 02H lowers the regulator output voltage.
// RQ12 - Software may re-enable interrupts, then triggers with mode 00 or 10.
// RQ13 - Software places five or more no-operations after the trigger store.
// RQ14 - Pending unmasked interrupt at trigger refuses entry; code continues.
// RQ15 - Interrupt controller stops but still detects release requests.
// RQ16 - Converter input side suspends and holds its conversion result.
// RQ17 - Converter output side suspends and holds its output value.
// RQ18 - Clocked serial units run only with external serial clock selected.
// RQ19 - Async serial unit zero runs only with its external clock.
// RQ20 - Watchdog and timer M run only with slow internal or subclock.
// RQ21 - Watch timer runs if main clock oscillates, else needs subclock.
// RQ22 - Ports and registers retained; realtime output stops, outputs held.
// RQ23 - Software clears the PLL enable before stopping the main clock.
// RQ24 - Interrupt release returns to subclock or low-voltage subclock mode.
// RQ25 - Clocks gated only after the trigger store has completed.
module sics_standby_ctrl
  import sics_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic subclk_mode,
  input wire sics_sw_type sw,
  input wire sics_clksel_type clksel,
  input wire logic int_pending,
  input wire logic wake_int,
  input wire logic wake_pin,
  output sics_clken_type clk_en_q,
  output sics_hold_type hold_q,
  output logic sub_idle_q,
  output logic lv_idle_q,
  output logic reg_low_q,
  output logic refused_q,
  output logic unlocked_q,
  output logic [7:0] level_q
);

  // ---------------------------------------------------------------
  // Regulator key guard
  // ---------------------------------------------------------------
  sics_reg_guard u_guard (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .prot_wr(sw.prot_wr),
    .lvl_wr(sw.lvl_wr),
    .wdata(sw.wdata),
    .unlocked_q(unlocked_q),
    .level_q(level_q)
  );

  // ---------------------------------------------------------------
  // Wake pin synchroniser
  // ---------------------------------------------------------------
  logic [1:0] wake_sync_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wake_sync_q <= SICS_SYNC_RST;
    end else if (ce) begin
      wake_sync_q <= {wake_sync_q[0], wake_pin};
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  sics_state_type state_q;
  sics_state_type state_d;
  sics_clken_type clk_en_d;
  sics_hold_type hold_d;

  wire lv_level = (level_q == SICS_LVL_LOW); // see RQ11
  wire mode_ok = (sw.save_mode_select == SICS_PSM_IDLE_A) ||
                 (sw.save_mode_select == SICS_PSM_IDLE_B);
  wire entry_req = subclk_mode & mode_ok & sw.standby_trigger_bit; // see RQ1
  wire in_run = (state_q == SICS_RUN);
  wire refuse = in_run & entry_req & int_pending; // see RQ14
  wire arm = in_run & entry_req & ~int_pending;
  wire release_req = wake_sync_q[1] | wake_int; // see RQ15
  wire idle_d = (state_d == SICS_IDLE);
  wire lv_idle_d = idle_d & lv_level; // see RQ2
  wire ext_ok = ~lv_level;

  always_comb begin
    state_d = state_q;
    case (state_q)
      SICS_RUN: begin
        if (arm) begin
          state_d = SICS_ARMED;
        end
      end
      SICS_ARMED: begin
        if (sw.store_done) begin
          state_d = SICS_IDLE; // see RQ25
        end
      end
      SICS_IDLE: begin
        if (release_req) begin
          state_d = SICS_RUN; // see RQ24
        end
      end
      default: begin
        state_d = SICS_RUN;
      end
    endcase
  end

  // Gating of clocks; subclock/external clocked units stay on, external ones only outside low-voltage sub-idle, see RQ5
  assign clk_en_d.cpu = ~idle_d; // see RQ3
  assign clk_en_d.flash = ~idle_d; // see RQ3
  assign clk_en_d.periph = ~idle_d; // see RQ3
  assign clk_en_d.csi = idle_d ?
    (clksel.serial_ext_clock_sel & {SICS_NCSI{ext_ok}}) :
    {SICS_NCSI{1'b1}}; // see RQ18
  assign clk_en_d.uart0 = ~idle_d |
    (clksel.async_ext_clock_sel & ext_ok); // see RQ19
  assign clk_en_d.tmm = ~idle_d | clksel.tmm_slow_sel; // see RQ20
  assign clk_en_d.wdt = ~idle_d | clksel.wdt_slow_sel; // see RQ20
  assign clk_en_d.wt = ~idle_d | clksel.main_osc_on |
    clksel.wt_sub_sel; // see RQ21

  // Held functions
  assign hold_d.adc = idle_d; // see RQ16
  assign hold_d.dac = idle_d; // see RQ17
  assign hold_d.realtime_output_unit = idle_d; // see RQ22
  assign hold_d.ports = idle_d; // see RQ22
  assign hold_d.ram = idle_d; // see RQ4
  assign hold_d.intc_wake_only = idle_d; // see RQ15

  // ---------------------------------------------------------------
  // State and output registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= SICS_RUN;
      clk_en_q <= '1;
      hold_q <= '0;
      sub_idle_q <= 1'b0;
      lv_idle_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      clk_en_q <= clk_en_d;
      hold_q <= hold_d;
      sub_idle_q <= idle_d;
      lv_idle_q <= lv_idle_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_low_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (ce) begin
      reg_low_q <= lv_level; // see RQ11
      refused_q <= refuse; // see RQ14
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_entry_arms: assert property ( // see RQ1
    ce && arm |=> state_q == SICS_ARMED
  ) else $error("valid trigger did not arm entry");

  a_mode_ignored: assert property ( // see RQ1
    ce && in_run && sw.standby_trigger_bit && !mode_ok
      |=> state_q == SICS_RUN && !refused_q
  ) else $error("trigger with bad mode was taken");

  a_subclk_only: assert property ( // see RQ1
    ce && in_run && !subclk_mode |=> state_q == SICS_RUN
  ) else $error("trigger taken outside subclock operation");

  a_refuse_pending: assert property ( // see RQ14
    ce && in_run && entry_req && int_pending |=> refused_q && !sub_idle_q
  ) else $error("entry taken with interrupt pending");

  a_refuse_stays: assert property ( // see RQ14
    ce && refuse |=> state_q == SICS_RUN
  ) else $error("refused entry left the run state");

  a_gate_after_store: assert property ( // see RQ25
    ce && state_q == SICS_ARMED && !sw.store_done |=> clk_en_q.cpu
  ) else $error("clock gated before store completed");

  a_no_direct_gate: assert property ( // see RQ25
    ce && in_run |=> !sub_idle_q
  ) else $error("clocks gated straight from run");

  a_idle_gating: assert property ( // see RQ3
    sub_idle_q |-> !clk_en_q.cpu && !clk_en_q.flash && !clk_en_q.periph
      && hold_q.ram
  ) else $error("core clocks running in sub-idle");

  a_run_clocks: assert property ( // see RQ24
    !sub_idle_q |-> clk_en_q == '1 && hold_q == '0
  ) else $error("clock gated or function held outside sub-idle");

  a_lv_entry: assert property ( // see RQ2
    ce && state_q == SICS_ARMED && sw.store_done && lv_level
      |=> lv_idle_q && sub_idle_q
  ) else $error("low-voltage sub-idle not entered");

  a_plain_entry: assert property ( // see RQ2
    ce && state_q == SICS_ARMED && sw.store_done && !lv_level
      |=> sub_idle_q && !lv_idle_q
  ) else $error("plain sub-idle not entered");

  a_locked_level: assert property ( // see RQ10
    ce && sw.lvl_wr && !unlocked_q && !sw.prot_wr |=> $stable(level_q)
  ) else $error("level written while locked");

  a_unlock_key: assert property ( // see RQ10
    ce && sw.prot_wr
      |=> unlocked_q == ($past(sw.wdata) == SICS_PROT_KEY)
  ) else $error("unlock flag does not follow the key");

  a_level_take: assert property ( // see RQ10
    ce && sw.lvl_wr && unlocked_q |=> level_q == $past(sw.wdata)
  ) else $error("unlocked level write was lost");

  a_low_reg: assert property ( // see RQ11
    ce && sw.lvl_wr && unlocked_q && sw.wdata == SICS_LVL_LOW
      ##1 ce |=> reg_low_q
  ) else $error("regulator not lowered");

  a_hold_set: assert property ( // see RQ16
    sub_idle_q |-> hold_q.adc && hold_q.dac && hold_q.realtime_output_unit
      && hold_q.intc_wake_only
  ) else $error("converter or output not held");

  a_ports_held: assert property ( // see RQ22
    ce && state_d == SICS_IDLE |=> hold_q.ports && hold_q.realtime_output_unit
  ) else $error("ports or realtime output not held");

  a_csi_ext: assert property ( // see RQ18
    ce && state_q == SICS_IDLE && !release_req && !lv_level
      |=> clk_en_q.csi == $past(clksel.serial_ext_clock_sel)
  ) else $error("serial unit clock wrong in sub-idle");

  a_lv_ext_off: assert property ( // see RQ18
    ce && state_d == SICS_IDLE && lv_level
      |=> clk_en_q.csi == '0 && !clk_en_q.uart0
  ) else $error("external clocked unit on in low-voltage sub-idle");

  a_uart_ext: assert property ( // see RQ19
    ce && state_q == SICS_IDLE && !release_req && !lv_level
      |=> clk_en_q.uart0 == $past(clksel.async_ext_clock_sel)
  ) else $error("async unit clock wrong in sub-idle");

  a_tmm_select: assert property ( // see RQ20
    ce && state_d == SICS_IDLE
      |=> clk_en_q.tmm == $past(clksel.tmm_slow_sel)
  ) else $error("timer M clock wrong in sub-idle");

  a_wdt_select: assert property ( // see RQ20
    ce && state_d == SICS_IDLE
      |=> clk_en_q.wdt == $past(clksel.wdt_slow_sel)
  ) else $error("watchdog clock wrong in sub-idle");

  a_wt_main: assert property ( // see RQ21
    ce && state_d == SICS_IDLE && clksel.main_osc_on |=> clk_en_q.wt
  ) else $error("watch timer stopped with main clock on");

  a_wt_sub: assert property ( // see RQ21
    ce && state_d == SICS_IDLE && !clksel.main_osc_on
      |=> clk_en_q.wt == $past(clksel.wt_sub_sel)
  ) else $error("watch timer clock wrong with main clock off");

  a_wake_return: assert property ( // see RQ24
    ce && state_q == SICS_IDLE && wake_int |=> !sub_idle_q ##1 !sub_idle_q
  ) else $error("no return after wake");

  a_pin_release: assert property ( // see RQ15
    ce && state_q == SICS_IDLE && wake_sync_q[1]
      |=> !sub_idle_q && hold_q == '0
  ) else $error("synchronised wake pin did not release");

  a_lv_return: assert property ( // see RQ24
    ce && state_q == SICS_IDLE && release_req && lv_level
      |=> !sub_idle_q && reg_low_q
  ) else $error("low-voltage operation lost on release");

  a_freeze_state: assert property (
    !ce |=> $stable(state_q) && $stable(clk_en_q) && $stable(hold_q)
      && $stable(wake_sync_q) && $stable(level_q)
  ) else $error("state changed while clock enable low");

  c_enter_idle: cover property (ce && state_q == SICS_ARMED ##1 sub_idle_q);
  c_enter_lv: cover property (lv_idle_q);
  c_refused: cover property (refused_q);
  c_wake: cover property (sub_idle_q ##1 !sub_idle_q);

endmodule // sics_standby_ctrl

// >>> sics_sw_model.sv
module sics_sw_model
  import sics_pkg::*;
(
  output sics_sw_type sw,
  output logic main_osc_on,
  input wire logic mclk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pll_on;
  logic quiet;
  initial begin
    sw = '0;
    main_osc_on = 1'b1;
    pll_on = 1'b1;
    quiet = 1'b0;
  end
  // ----------
  // Store cycles
  // ----------
  task automatic put(input sics_sw_type v);
    sw = v;
    @(posedge mclk);
    #1;
  endtask
  task automatic idle();
    put('0);
  endtask
  task automatic wr(input logic prot, input logic [7:0] d);
    put({4'h0, prot, !prot, d});
  endtask
  task automatic trig(input logic [1:0] m);
    put({m, 4'h8, 8'h00});
  endtask
  task automatic store();
    put({2'h0, 4'h4, 8'h00});
    repeat (5) idle();
  endtask
  task automatic lv_prep();
    pll_on = 1'b0;
    main_osc_on = 1'b0;
    quiet = 1'b1;
    wr(1'b1, SICS_PROT_KEY);
    wr(1'b0, SICS_LVL_LOW);
    wr(1'b1, SICS_PROT_LOCK);
    idle();
    quiet = 1'b0;
  endtask
endmodule // sics_sw_model

// >>> testbench.sv
module testbench
  import sics_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst, ce, subclk_mode, int_pending, wake_int, wake_pin, osc;
  logic [9:0] sel;
  sics_sw_type sw;
  sics_clken_type clk_en_q;
  sics_hold_type hold_q;
  logic sub_idle_q, lv_idle_q, reg_low_q, refused_q, unlocked_q;
  logic [7:0] level_q;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  sics_sw_model sm (.mclk(mclk), .sw(sw), .main_osc_on(osc));
  sics_standby_ctrl dut (
    .mclk(mclk), .rst(rst), .ce(ce), .subclk_mode(subclk_mode), .sw(sw),
    .clksel(sics_clksel_type'({sel[9:1], osc})),
    .int_pending(int_pending), .wake_int(wake_int), .wake_pin(wake_pin),
    .clk_en_q(clk_en_q), .hold_q(hold_q), .sub_idle_q(sub_idle_q),
    .lv_idle_q(lv_idle_q), .reg_low_q(reg_low_q), .refused_q(refused_q),
    .unlocked_q(unlocked_q), .level_q(level_q)
  );

  always #25 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 3000) begin
      fail_count++;
      conclude();
    end
  end

  // ----------
  // Helpers
  // ----------
  task automatic check(input string what, input logic [19:0] seen,
                       input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic sics_clken_type exp_en(input logic lv);
    return {3'h0, sel[9:5] & {5{!lv}}, sel[4] & !lv, sel[3:2], osc | sel[1]};
  endfunction

  // ----------
  // Scenarios
  // ----------
  task automatic t_ignore();
    subclk_mode = 1'b0;
    sm.trig(2'h0);
    sm.idle();
    subclk_mode = 1'b1;
    sm.trig(2'h1);
    sm.idle();
    sm.trig(2'h3);
    sm.store();
    check("ignored", {sub_idle_q, refused_q}, 0);
  endtask

  task automatic t_refuse();
    int_pending = 1'b1;
    sm.trig(2'h2);
    check("refused", {refused_q, sub_idle_q}, 2'b10);
    sm.idle();
    int_pending = 1'b0;
    check("refused_end", refused_q, 0);
    sm.store();
    check("no_entry", sub_idle_q, 0);
  endtask

  task automatic enter(input logic [1:0] m, input logic lv, input logic pin);
    int n;
    sm.trig(m);
    sm.idle();
    check("armed", {sub_idle_q, clk_en_q.cpu}, 2'b01);
    sm.store();
    check("mode", {sub_idle_q, lv_idle_q}, {1'b1, lv});
    check("clk_en", clk_en_q, exp_en(lv));
    check("hold", hold_q, 6'h3f);
    wake_pin = pin;
    wake_int = !pin;
    n = 0;
    while (sub_idle_q === 1'b1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    wake_pin = 1'b0;
    wake_int = 1'b0;
    check("wake", 20'(n), pin ? 20'h3 : 20'h1);
    check("run_en", clk_en_q, 12'hfff);
    check("run_hold", {hold_q, reg_low_q}, {6'h0, lv});
  endtask

  task automatic t_freeze();
    sm.trig(2'h0);
    ce = 1'b0;
    sm.store();
    check("frozen", {sub_idle_q, clk_en_q.cpu}, 2'b01);
    ce = 1'b1;
    sm.store();
    check("thawed", sub_idle_q, 1'b1);
    wake_int = 1'b1;
    sm.idle();
    wake_int = 1'b0;
    check("woken", {sub_idle_q, clk_en_q.cpu}, 2'b01);
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    subclk_mode = 1'b1;
    int_pending = 1'b0;
    wake_int = 1'b0;
    wake_pin = 1'b0;
    sel = 10'h2b8;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    check("rst_en", clk_en_q, 12'hfff);
    check("rst_st", {hold_q, sub_idle_q, lv_idle_q, reg_low_q, refused_q,
      unlocked_q, level_q}, 0);
    t_ignore();
    t_refuse();
    t_freeze();
    enter(2'h0, 1'b0, 1'b0);
    sel = 10'h146;
    enter(2'h2, 1'b0, 1'b1);
    sm.wr(1'b0, 8'h02);
    sm.idle();
    check("locked", {level_q, reg_low_q}, 0);
    sm.lv_prep();
    check("level", {level_q, unlocked_q, reg_low_q}, 10'h009);
    sel = 10'h3fe;
    enter(2'h2, 1'b1, 1'b1);
    sel = 10'h3f4;
    enter(2'h0, 1'b1, 1'b0);
    conclude();
  end
endmodule // testbench
